// ### host_bus_gpio_serial_regs.sv
// Host register port: strobe handshake, port and serial unit registers.
// Assumes host strobes are synchronous to clk and the address holds through an access.
`include "host_bus_consts.svh"
`timescale 1ns/10ps

module host_bus_gpio_serial_regs #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             chip_select_n,
    input  wire logic             data_strobe_n,
    input  wire logic             read_not_write,
    input  wire logic [4:0]       reg_addr,
    input  wire logic [7:0]       host_data_bus_in,
    output logic      [7:0]       host_data_bus_out,
    output logic                  host_data_bus_oe,
    output logic                  transfer_ack_n,
    output logic                  transfer_ack_oe,
    input  wire logic [WIDTH-1:0] port_pins_in,
    output logic      [WIDTH-1:0] port_pins_out,
    output logic      [WIDTH-1:0] port_pins_oe,
    output logic      [WIDTH-1:0] port_edge_event,
    output logic      [7:0]       serial_control_q,
    output logic      [1:0]       rx_control_q,
    output logic      [7:0]       tx_control_q,
    input  wire logic [5:0]       rx_status_flags,
    input  wire logic [2:0]       tx_status_flags,
    input  wire logic [7:0]       rx_byte,
    output logic      [7:0]       tx_byte,
    output logic                  tx_load,
    output logic                  rx_read,
    output logic                  rx_error,
    output logic                  tx_error,
    input  wire logic             tx_engine_bit,
    input  wire logic             serial_in,
    output logic                  serial_out,
    output logic                  serial_out_oe,
    output logic                  rx_line
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    host_bus_pkg::bus_state_t state_r;
    host_bus_pkg::bus_state_t state_nxt;
    logic             sel;
    logic [7:0]       rd_nxt;
    logic [7:0]       wr_data_r;
    logic [4:0]       wr_addr_r;
    logic             wr_commit;
    logic             rd_start;
    logic [WIDTH-1:0] dir_r;
    logic [WIDTH-1:0] edge_sel_r;
    logic [WIDTH-1:0] data_out_r;
    logic [7:0]       ucr_r;
    logic [1:0]       rx_ctl_r;
    logic [7:0]       tx_ctl_r;

    gpio_ctl_if #(.WIDTH(WIDTH)) gpio_ctl ();
    serial_ctl_if                ser_ctl ();

    assign gpio_ctl.dir      = dir_r;
    assign gpio_ctl.edge_sel = edge_sel_r;
    assign gpio_ctl.data_out = data_out_r;
    assign ser_ctl.tx_enable = tx_ctl_r[`TXST_ENABLE_BIT];
    assign ser_ctl.out_state =
        host_bus_pkg::out_state_t'(tx_ctl_r[`TXST_STATE_MSB:`TXST_STATE_LSB]);

    // ----------------------------------------
    // Strobe handshake
    // ----------------------------------------
    assign sel = ~chip_select_n & ~data_strobe_n;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            host_bus_pkg::BUS_IDLE: begin
                if (sel && read_not_write) begin
                    state_nxt = host_bus_pkg::BUS_READ;
                end else if (sel) begin
                    state_nxt = host_bus_pkg::BUS_WRITE;
                end
            end
            host_bus_pkg::BUS_READ: begin
                if (!sel) begin
                    state_nxt = host_bus_pkg::BUS_RELEASE;
                end
            end
            host_bus_pkg::BUS_WRITE: begin
                if (data_strobe_n || chip_select_n) begin
                    state_nxt = host_bus_pkg::BUS_RELEASE;
                end
            end
            host_bus_pkg::BUS_RELEASE: begin
                state_nxt = host_bus_pkg::BUS_IDLE;
            end
        endcase
    end

    assign wr_commit = (state_r == host_bus_pkg::BUS_WRITE)
                     && (state_nxt == host_bus_pkg::BUS_RELEASE);
    assign rd_start  = (state_r == host_bus_pkg::BUS_IDLE)
                     && (state_nxt == host_bus_pkg::BUS_READ);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= host_bus_pkg::BUS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Acknowledge driven high for one cycle before floating, so the line
    // does not rely on a slow pull-up to return inactive.
    always_ff @(posedge clk) begin
        if (rst) begin
            transfer_ack_n  <= 1'b1;
            transfer_ack_oe <= 1'b0;
        end else begin
            transfer_ack_n  <= !(state_nxt == host_bus_pkg::BUS_READ
                               || state_nxt == host_bus_pkg::BUS_WRITE);
            transfer_ack_oe <= (state_nxt != host_bus_pkg::BUS_IDLE);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            host_data_bus_oe  <= 1'b0;
            host_data_bus_out <= `RESET_BYTE;
        end else begin
            host_data_bus_oe  <= (state_nxt == host_bus_pkg::BUS_READ);
            host_data_bus_out <= rd_nxt;
        end
    end

    // Write data is the last bus sample taken while the strobe was low
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_data_r <= `RESET_BYTE;
            wr_addr_r <= 5'h00;
        end else if (state_nxt == host_bus_pkg::BUS_WRITE) begin
            wr_data_r <= host_data_bus_in;
            wr_addr_r <= reg_addr;
        end
    end

    // ----------------------------------------
    // Read multiplexer
    // ----------------------------------------
    always_comb begin
        rd_nxt = `RESET_BYTE;
        unique case (reg_addr)
            `ADDR_PORT_LINE_DATA:   rd_nxt = gpio_ctl.pin_level;
            `ADDR_PORT_EDGE_SELECT: rd_nxt = edge_sel_r;
            `ADDR_PORT_DIRECTION:   rd_nxt = dir_r;
            `ADDR_SERIAL_CONTROL:   rd_nxt = ucr_r & `SERIAL_CONTROL_MASK;
            `ADDR_SERIAL_RX_STATUS: rd_nxt = {rx_status_flags, rx_ctl_r};
            `ADDR_SERIAL_TX_STATUS: rd_nxt = {tx_status_flags[2:1],
                                              tx_ctl_r[`TXST_AUTO_TURN_BIT],
                                              tx_status_flags[0],
                                              tx_ctl_r[3:0]};
            `ADDR_SERIAL_DATA:      rd_nxt = rx_byte;
            default:                rd_nxt = `RESET_BYTE;
        endcase
    end

    // ----------------------------------------
    // Port registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            data_out_r <= `RESET_BYTE;
            edge_sel_r <= `RESET_BYTE;
            dir_r      <= `RESET_BYTE;
        end else if (wr_commit) begin
            if (wr_addr_r == `ADDR_PORT_LINE_DATA) begin
                data_out_r <= wr_data_r;
            end
            if (wr_addr_r == `ADDR_PORT_EDGE_SELECT) begin
                edge_sel_r <= wr_data_r;
            end
            if (wr_addr_r == `ADDR_PORT_DIRECTION) begin
                dir_r <= wr_data_r;
            end
        end
    end

    // ----------------------------------------
    // Serial unit registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ucr_r    <= `RESET_BYTE;
            rx_ctl_r <= 2'h0;
            tx_ctl_r <= `RESET_BYTE;
        end else if (wr_commit) begin
            if (wr_addr_r == `ADDR_SERIAL_CONTROL) begin
                ucr_r <= wr_data_r & `SERIAL_CONTROL_MASK;
            end
            if (wr_addr_r == `ADDR_SERIAL_RX_STATUS) begin
                rx_ctl_r <= wr_data_r[1:0];
            end
            if (wr_addr_r == `ADDR_SERIAL_TX_STATUS) begin
                tx_ctl_r <= wr_data_r & `TX_STATUS_WR_MASK;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_byte <= `RESET_BYTE;
            tx_load <= 1'b0;
            rx_read <= 1'b0;
        end else begin
            tx_load <= wr_commit && (wr_addr_r == `ADDR_SERIAL_DATA);
            rx_read <= rd_start && (reg_addr == `ADDR_SERIAL_DATA);
            if (wr_commit && (wr_addr_r == `ADDR_SERIAL_DATA)) begin
                tx_byte <= wr_data_r;
            end
        end
    end

    // Flags track the live boundary status; capture is left to the
    // interrupt controller, which is why nothing here is sticky.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_error <= 1'b0;
            tx_error <= 1'b0;
        end else begin
            rx_error <= |rx_status_flags[`RX_FLAG_OVERRUN_BIT:`RX_FLAG_FRAME_BIT];
            tx_error <= tx_status_flags[`TX_FLAG_UNDERRUN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            serial_control_q <= `RESET_BYTE;
            rx_control_q     <= 2'h0;
            tx_control_q     <= `RESET_BYTE;
            port_edge_event  <= `RESET_BYTE;
        end else begin
            serial_control_q <= ucr_r;
            rx_control_q     <= rx_ctl_r;
            tx_control_q     <= tx_ctl_r;
            port_edge_event  <= gpio_ctl.edge_event;
        end
    end

    // ----------------------------------------
    // Sub-blocks
    // ----------------------------------------
    gpio_port #(.WIDTH(WIDTH)) u_gpio (
        .clk      (clk),
        .rst      (rst),
        .ctl      (gpio_ctl.port),
        .pins_in  (port_pins_in),
        .pins_out (port_pins_out),
        .pins_oe  (port_pins_oe)
    );

    serial_line u_line (
        .clk           (clk),
        .rst           (rst),
        .ctl           (ser_ctl.line),
        .tx_engine_bit (tx_engine_bit),
        .serial_in     (serial_in),
        .serial_out    (serial_out),
        .serial_out_oe (serial_out_oe),
        .rx_line       (rx_line)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_READ_DRIVE: assert property (
        (state_r == host_bus_pkg::BUS_IDLE) && sel && read_not_write
        |=> host_data_bus_oe && !transfer_ack_n)
        else $error("read did not drive bus and acknowledge");

    AST_READ_END: assert property (
        (state_r == host_bus_pkg::BUS_READ) && !sel |=> !host_data_bus_oe)
        else $error("bus still driven after strobe release");

    AST_FLOAT: assert property (
        host_data_bus_oe |-> (state_r == host_bus_pkg::BUS_READ))
        else $error("bus driven outside read");

    AST_WRITE_ACK: assert property (
        (state_r == host_bus_pkg::BUS_IDLE) && sel && !read_not_write
        |=> !transfer_ack_n && transfer_ack_oe && !host_data_bus_oe)
        else $error("write not acknowledged");

    AST_ACK_DROP: assert property (
        (state_r == host_bus_pkg::BUS_WRITE) && data_strobe_n
        |=> transfer_ack_n && transfer_ack_oe ##1 !transfer_ack_oe)
        else $error("acknowledge not withdrawn");

    AST_DIR_STORE: assert property (
        wr_commit && (wr_addr_r == `ADDR_PORT_DIRECTION)
        |=> dir_r == $past(wr_data_r) ##1 port_pins_oe == $past(dir_r))
        else $error("direction write not applied");

    AST_TX_LOAD: assert property (
        wr_commit && (wr_addr_r == `ADDR_SERIAL_DATA)
        |=> tx_load && tx_byte == $past(wr_data_r) ##1 !tx_load)
        else $error("serial byte not handed over");

    AST_UCR_ZERO: assert property (
        !ucr_r[0] && !serial_control_q[0])
        else $error("unused control bit set");

    AST_LOW_STATE: assert property (
        !tx_ctl_r[`TXST_ENABLE_BIT] && ser_ctl.out_state == host_bus_pkg::OUT_LOW
        && $stable(tx_ctl_r) |=> !serial_out && serial_out_oe)
        else $error("low output state not driven");

    AST_ERR_LIVE: assert property (
        !tx_status_flags[`TX_FLAG_UNDERRUN_BIT] |=> !tx_error)
        else $error("transmit error flag held");

    COV_READ: cover property (
        (state_r == host_bus_pkg::BUS_READ) ##1 (state_r == host_bus_pkg::BUS_RELEASE));
    COV_WRITE: cover property (wr_commit);
    COV_EDGE: cover property (|port_edge_event);
    COV_LOOP: cover property (ser_ctl.out_state == host_bus_pkg::OUT_LOOP);

endmodule

// ### host_bus_consts.svh
// Register offsets, field positions and reset values of the host register port.
// Assumes the host address lines A1..A5 arrive as a 5-bit word index.
`ifndef HOST_BUS_CONSTS_SVH
`define HOST_BUS_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_PORT_LINE_DATA      5'h00
`define ADDR_PORT_EDGE_SELECT    5'h01
`define ADDR_PORT_DIRECTION      5'h02
`define ADDR_SERIAL_CONTROL      5'h0C
`define ADDR_SERIAL_RX_STATUS    5'h15
`define ADDR_SERIAL_TX_STATUS    5'h16
`define ADDR_SERIAL_DATA         5'h17

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define RESET_BYTE               8'h00
`define SERIAL_CONTROL_MASK      8'hFE
`define RX_STATUS_WR_MASK        8'h03
`define TX_STATUS_WR_MASK        8'h2F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TXST_ENABLE_BIT          0
`define TXST_STATE_LSB           1
`define TXST_STATE_MSB           2
`define TXST_AUTO_TURN_BIT       5
`define RX_FLAG_OVERRUN_BIT      4
`define RX_FLAG_FRAME_BIT        2
`define TX_FLAG_UNDERRUN_BIT     1

`endif

// ### host_bus_pkg.sv
// Types shared by the host register port and its sub-blocks.
// Assumes nothing beyond a SystemVerilog compiler.
package host_bus_pkg;

    typedef enum {
        BUS_IDLE,
        BUS_READ,
        BUS_WRITE,
        BUS_RELEASE
    } bus_state_t;

    typedef enum logic [1:0] {
        OUT_HIZ  = 2'b00,
        OUT_LOW  = 2'b01,
        OUT_HIGH = 2'b10,
        OUT_LOOP = 2'b11
    } out_state_t;

endpackage

// ### port_ctl_if.sv
// Carriers between the register file and the port and serial line blocks.
// Assumes all parties share one clock.
`timescale 1ns/10ps

interface gpio_ctl_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] edge_sel;
    logic [WIDTH-1:0] data_out;
    logic [WIDTH-1:0] pin_level;
    logic [WIDTH-1:0] edge_event;
    modport regs (output dir, output edge_sel, output data_out,
                  input pin_level, input edge_event);
    modport port (input dir, input edge_sel, input data_out,
                  output pin_level, output edge_event);
endinterface

interface serial_ctl_if;
    logic                    tx_enable;
    host_bus_pkg::out_state_t out_state;
    modport regs (output tx_enable, output out_state);
    modport line (input tx_enable, input out_state);
endinterface

// ### gpio_port.sv
// General purpose lines: direction, output drive, level sampling, edge events.
// Assumes pin inputs are synchronous to clk.
`timescale 1ns/10ps

module gpio_port #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    gpio_ctl_if.port              ctl,
    input  wire logic [WIDTH-1:0] pins_in,
    output logic      [WIDTH-1:0] pins_out,
    output logic      [WIDTH-1:0] pins_oe
);
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] prev_r;
    logic [WIDTH-1:0] event_r;

    assign ctl.pin_level  = level_r;
    assign ctl.edge_event = event_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_line
            always_ff @(posedge clk) begin
                if (rst) begin
                    level_r[i]  <= 1'b0;
                    prev_r[i]   <= 1'b0;
                    event_r[i]  <= 1'b0;
                    pins_out[i] <= 1'b0;
                    pins_oe[i]  <= 1'b0;
                end else begin
                    // Output lines read back what they drive
                    level_r[i]  <= ctl.dir[i] ? ctl.data_out[i] : pins_in[i];
                    prev_r[i]   <= level_r[i];
                    event_r[i]  <= ctl.edge_sel[i] ? (level_r[i] & ~prev_r[i])
                                                   : (~level_r[i] & prev_r[i]);
                    pins_out[i] <= ctl.data_out[i];
                    pins_oe[i]  <= ctl.dir[i];
                end
            end
        end
    endgenerate

endmodule

// ### serial_line.sv
// Serial output pin steering: transmitter bit when enabled, else fixed state.
// Assumes the shift engine outside supplies tx_engine_bit.
`timescale 1ns/10ps

module serial_line (
    input  wire logic clk,
    input  wire logic rst,
    serial_ctl_if.line ctl,
    input  wire logic tx_engine_bit,
    input  wire logic serial_in,
    output logic      serial_out,
    output logic      serial_out_oe,
    output logic      rx_line
);
    always_ff @(posedge clk) begin
        if (rst) begin
            serial_out    <= 1'b1;
            serial_out_oe <= 1'b0;
            rx_line       <= 1'b1;
        end else if (ctl.tx_enable) begin
            serial_out    <= tx_engine_bit;
            serial_out_oe <= 1'b1;
            rx_line       <= (ctl.out_state == host_bus_pkg::OUT_LOOP) ? tx_engine_bit
                                                                       : serial_in;
        end else begin
            unique case (ctl.out_state)
                host_bus_pkg::OUT_HIZ: begin
                    serial_out    <= 1'b1;
                    serial_out_oe <= 1'b0;
                end
                host_bus_pkg::OUT_LOW: begin
                    serial_out    <= 1'b0;
                    serial_out_oe <= 1'b1;
                end
                host_bus_pkg::OUT_HIGH, host_bus_pkg::OUT_LOOP: begin
                    serial_out    <= 1'b1;
                    serial_out_oe <= 1'b1;
                end
            endcase
            // Loopback feeds the receiver from the idle-high transmitter side
            rx_line <= (ctl.out_state == host_bus_pkg::OUT_LOOP) ? 1'b1 : serial_in;
        end
    end

endmodule

// ### host_master_model.sv
// Host side of the strobe bus: one read or write cycle per call.
// Assumes the device acknowledges active low, synchronous to clk.
`timescale 1ns/10ps

module host_master_model (
    input  wire logic       clk,
    output logic            cs_n,
    output logic            ds_n,
    output logic            rw,
    output logic [4:0]      addr,
    output logic [7:0]      bus_in,
    input  wire logic [7:0] dev_out,
    input  wire logic       dev_oe,
    input  wire logic       ack_n
);
    logic [7:0] drv;
    logic       drv_on;

    // Released bus shows the inverse, so a stale value cannot pass
    assign bus_in = dev_oe ? dev_out : (drv_on ? drv : ~drv);

    initial begin
        cs_n = 1'b1;
        ds_n = 1'b1;
        rw = 1'b1;
        addr = 5'h00;
        drv = 8'h00;
        drv_on = 1'b0;
    end

    task automatic access(input logic r, input logic [4:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ok, output int rel);
        int n;
        @(negedge clk);
        rw = r;
        addr = a;
        drv = d;
        drv_on = !r;
        cs_n = 1'b0;
        ds_n = 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ack_n !== 1'b0 && n < 20);
        ok = (ack_n === 1'b0);
        q = bus_in;
        ds_n = 1'b1;
        cs_n = 1'b1;
        rel = 0;
        do begin
            @(negedge clk);
            rel++;
        end while (ack_n !== 1'b1 && rel < 6);
        drv_on = 1'b0;
        @(negedge clk);
    endtask
endmodule

// ### tb_host_bus_gpio_serial_regs.sv
// Self-checking bench for the host register port.
// Assumes the host model above and the register constants header.
`include "host_bus_consts.svh"
`timescale 1ns/10ps

module tb_host_bus_gpio_serial_regs;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       ev_clr = 1'b1;
    logic       cs_n, ds_n, rw, ack_n, ack_oe, oe, tx_load, rx_read;
    logic       rx_err, tx_err, sout, sout_oe, rx_line;
    logic [4:0] addr;
    logic [7:0] bin, bout, pins, pout, poe, pev, ucq, txq, txb, rxb, ev_seen;
    logic [1:0] rxq;
    logic [5:0] rxf;
    logic [2:0] txf;
    int         num_errors = 0;
    int         compares = 0;
    int         cyc = 0;
    int         n_load = 0;
    int         n_read = 0;

    always #4 clk = ~clk;

    host_master_model host (.clk(clk), .cs_n(cs_n), .ds_n(ds_n), .rw(rw), .addr(addr),
        .bus_in(bin), .dev_out(bout), .dev_oe(oe), .ack_n(ack_n));

    host_bus_gpio_serial_regs #(.WIDTH(8)) dut (.clk(clk), .rst(rst), .chip_select_n(cs_n),
        .data_strobe_n(ds_n), .read_not_write(rw), .reg_addr(addr),
        .host_data_bus_in(bin), .host_data_bus_out(bout), .host_data_bus_oe(oe),
        .transfer_ack_n(ack_n), .transfer_ack_oe(ack_oe), .port_pins_in(pins),
        .port_pins_out(pout), .port_pins_oe(poe), .port_edge_event(pev),
        .serial_control_q(ucq), .rx_control_q(rxq), .tx_control_q(txq),
        .rx_status_flags(rxf), .tx_status_flags(txf), .rx_byte(rxb), .tx_byte(txb),
        .tx_load(tx_load), .rx_read(rx_read), .rx_error(rx_err), .tx_error(tx_err),
        .tx_engine_bit(1'b0), .serial_in(1'b1), .serial_out(sout),
        .serial_out_oe(sout_oe), .rx_line(rx_line));

    always @(posedge clk) begin
        cyc++;
        ev_seen <= ev_clr ? 8'h00 : (ev_seen | pev);
        if (tx_load === 1'b1) n_load++;
        if (rx_read === 1'b1) n_read++;
        if (cyc == 5000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Checks and bus tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input logic r, input logic [4:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        logic ok;
        int   rel;
        host.access(r, a, d, q, ok, rel);
        chk("ack", 8'h01, {7'h00, ok});
        chk("ack release", 8'h01, rel[7:0]);
        chk("bus enable", 8'h00, {7'h00, oe});
        chk("ack enable", 8'h00, {7'h00, ack_oe});
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b0, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b1, a, 8'h00, q);
        chk("read data", exp, q);
    endtask

    task automatic end_of_test;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        pins = 8'h5A;
        rxf = 6'h00;
        txf = 3'h0;
        rxb = 8'h00;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        rd(`ADDR_SERIAL_CONTROL, 8'h00);
        wr(`ADDR_PORT_DIRECTION, 8'hF0);
        chk("pin enables", 8'hF0, poe);
        wr(`ADDR_PORT_LINE_DATA, 8'hA5);
        chk("pin outputs", 8'hA0, pout & poe);
        rd(`ADDR_PORT_LINE_DATA, 8'hAA);
        rd(`ADDR_PORT_DIRECTION, 8'hF0);
        wr(`ADDR_PORT_EDGE_SELECT, 8'h0F);
        rd(`ADDR_PORT_EDGE_SELECT, 8'h0F);
        wr(`ADDR_SERIAL_CONTROL, 8'hFF);
        rd(`ADDR_SERIAL_CONTROL, 8'hFE);
        chk("control copy", 8'hFE, ucq);
        // Unmapped place: write dropped, reads zero
        wr(5'h03, 8'h77);
        rd(5'h03, 8'h00);
        rxb = 8'h3C;
        rd(`ADDR_SERIAL_DATA, 8'h3C);
        chk("rx reads", 8'h01, n_read[7:0]);
        wr(`ADDR_SERIAL_DATA, 8'hC3);
        chk("tx byte", 8'hC3, txb);
        chk("tx loads", 8'h01, n_load[7:0]);
        for (int s = 0; s < 4; s++) begin
            wr(`ADDR_SERIAL_TX_STATUS, 8'(s << 1));
            repeat (2) @(negedge clk);
            chk("out enable", {7'h00, s != 0}, {7'h00, sout_oe});
            if (s != 0) chk("out level", {7'h00, s != 1}, {7'h00, sout});
        end
        rxf = 6'b010100;
        wr(`ADDR_SERIAL_RX_STATUS, 8'hFF);
        chk("rx control copy", 8'h03, {6'h00, rxq});
        rd(`ADDR_SERIAL_RX_STATUS, 8'h53);
        chk("rx error", 8'h01, {7'h00, rx_err});
        rxf = 6'h00;
        rd(`ADDR_SERIAL_RX_STATUS, 8'h03);
        chk("rx error", 8'h00, {7'h00, rx_err});
        txf = 3'b010;
        wr(`ADDR_SERIAL_TX_STATUS, 8'hFF);
        chk("tx control copy", 8'h2F, txq);
        chk("rx line", 8'h00, {7'h00, rx_line});
        rd(`ADDR_SERIAL_TX_STATUS, 8'h6F);
        chk("tx error", 8'h01, {7'h00, tx_err});
        txf = 3'b000;
        rd(`ADDR_SERIAL_TX_STATUS, 8'h2F);
        chk("tx error", 8'h00, {7'h00, tx_err});
        // Match driven levels first, so turning lines to inputs makes no edge
        pins = 8'hAA;
        wr(`ADDR_PORT_DIRECTION, 8'h00);
        pins = 8'h55;
        ev_clr = 1'b0;
        repeat (5) @(negedge clk);
        chk("edge events", 8'hA5, ev_seen);
        end_of_test();
    end
endmodule
